/* hw/ptd_defines.vh */
// Constants shared by the two-channel power-of-two decimator files.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

// ==========================================================
// Stream layout
`define PTD_WORD_W 32
`define PTD_SAMPLE_W 16
`define PTD_LO_MSB 15
`define PTD_LO_LSB 0
`define PTD_HI_MSB 31
`define PTD_HI_LSB 16

// ==========================================================
// Cascade and selection
`define PTD_STAGES 16
`define PTD_SEL_W 5
`define PTD_SEL_MAX 5'h10
`define PTD_SEL_RESET 5'h00

// ==========================================================
// Half-band taps, sum 512, centre tap 256
`define PTD_ACC_W 28
`define PTD_TAP_OUTER 28'sh0000003
`define PTD_TAP_MID 28'sh0000019
`define PTD_TAP_INNER 28'sh0000096
`define PTD_TAP_CENTRE 28'sh0000100
`define PTD_ROUND 28'sh0000100
`define PTD_SHIFT 9
`define PTD_SAT_POS 28'sh0007fff
`define PTD_SAT_NEG 28'shfff8000
`define PTD_HIST_W 160

// ==========================================================
// Output buffer
`define PTD_FIFO_DEPTH 32
`define PTD_FIFO_AW 5
`define PTD_LEVEL_W 6
`define PTD_FILL_LIMIT 6'h0c

`endif

/* hw/ptd_fifo.v */
// Parameterised first-word-fall-through FIFO with registered output.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps

module ptd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  // Words held in memory
  output reg [AW:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire wr;
  wire rd;

  assign in_ready = (level != DEPTH[AW:0]);
  assign wr = in_valid && in_ready;
  assign rd = (level != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  always @(posedge clk) begin
    if (wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (wr) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (rd) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      if (wr && !rd) begin
        level <= level + {{AW{1'b0}}, 1'b1};
      end else if (rd && !wr) begin
        level <= level - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* hw/ptd_pow2_decimator_core.v */
// Two-channel power-of-two decimator: sixteen half-band stages in
// cascade, a selected tap point, and a buffered AXI-Stream output.
// Assumes the selection source and both stream partners share mclk.
`timescale 1ns/100ps
`include "ptd_defines.vh"

// What this block does
// - Two 16-bit channels, one word per cycle.
// - Output rate is input over two^count.
// - Sixteen cascaded filter-then-halve stages.
// - Select zero bypasses, 1..16 picks stage.
// - Low half channel one, high half two.
// - TVALID/TREADY flow control on both streams.
// - Single written register holds the selection.
// - Passband near 60% of output Nyquist.
// - Unity gain inside the passband.
module ptd_pow2_decimator_core (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Selection write port
  input wire [4:0] decimation_select,
  input wire decimation_select_wr,
  // Selection status
  output reg [4:0] decimation_active,
  output reg select_rejected,
  // Input stream
  input wire s_axis_tvalid,
  output reg s_axis_tready,
  input wire [31:0] s_axis_tdata,
  // Output stream
  output wire m_axis_tvalid,
  input wire m_axis_tready,
  output wire [31:0] m_axis_tdata
);

  // ==========================================================
  // Reset release
  reg rst_meta;
  reg rst_n;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // Half-band filter on one channel
  // Window holds eleven samples, index zero the newest.
  function [15:0] ptd_halfband;
    input [159:0] hist;
    input [15:0] newest;
    reg [175:0] w;
    reg signed [27:0] acc;
    reg signed [27:0] scaled;
    begin
      w = {hist, newest};
      acc = `PTD_TAP_OUTER * ($signed(w[15:0]) +
            $signed(w[175:160]));
      acc = acc - `PTD_TAP_MID * ($signed(w[47:32]) +
            $signed(w[143:128]));
      acc = acc + `PTD_TAP_INNER * ($signed(w[79:64]) +
            $signed(w[111:96]));
      acc = acc + `PTD_TAP_CENTRE * $signed(w[95:80]);
      scaled = (acc + `PTD_ROUND) >>> `PTD_SHIFT;
      if (scaled > `PTD_SAT_POS) begin
        ptd_halfband = 16'h7fff;
      end else if (scaled < `PTD_SAT_NEG) begin
        ptd_halfband = 16'h8000;
      end else begin
        ptd_halfband = scaled[15:0];
      end
    end
  endfunction

  // ==========================================================
  // Selection register
  // Out-of-range writes are dropped and flagged for one cycle.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      decimation_active <= `PTD_SEL_RESET;
      select_rejected <= 1'b0;
    end else begin
      select_rejected <= 1'b0;
      if (decimation_select_wr) begin
        if (decimation_select > `PTD_SEL_MAX) begin
          select_rejected <= 1'b1;
        end else begin
          decimation_active <= decimation_select;
        end
      end
    end
  end

  // ==========================================================
  // Input acceptance
  wire s_accept;
  wire [16:0] st_valid;
  wire [31:0] st_data [0:16];

  assign s_accept = s_axis_tvalid && s_axis_tready;
  assign st_valid[0] = s_accept;
  assign st_data[0] = s_axis_tdata;

  // ==========================================================
  // Cascade of half-band stages
  // Each stage shifts on every input and emits on every second one,
  // so stage n runs at the input rate over two to the n.
  genvar g;
  generate
    for (g = 1; g <= `PTD_STAGES; g = g + 1) begin : stage
      reg [159:0] hist_lo;
      reg [159:0] hist_hi;
      reg phase;
      reg valid;
      reg [31:0] data;

      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          hist_lo <= {`PTD_HIST_W{1'b0}};
          hist_hi <= {`PTD_HIST_W{1'b0}};
          phase <= 1'b0;
          valid <= 1'b0;
          data <= 32'h00000000;
        end else begin
          valid <= 1'b0;
          if (st_valid[g-1]) begin
            hist_lo <= {hist_lo[143:0],
                        st_data[g-1][`PTD_LO_MSB:`PTD_LO_LSB]};
            hist_hi <= {hist_hi[143:0],
                        st_data[g-1][`PTD_HI_MSB:`PTD_HI_LSB]};
            phase <= ~phase;
            if (phase) begin
              valid <= 1'b1;
              // Coefficients sum to two to the shift, so gain is one
              data[`PTD_LO_MSB:`PTD_LO_LSB] <= ptd_halfband(hist_lo,
                st_data[g-1][`PTD_LO_MSB:`PTD_LO_LSB]);
              data[`PTD_HI_MSB:`PTD_HI_LSB] <= ptd_halfband(hist_hi,
                st_data[g-1][`PTD_HI_MSB:`PTD_HI_LSB]);
            end
          end
        end
      end

      // Taps are an eleven-point half-band, roughly 0.6 passband
      assign st_valid[g] = valid;
      assign st_data[g] = data;
    end
  endgenerate

  // ==========================================================
  // Tap point selection into the output buffer
  reg fifo_wr_valid;
  reg [31:0] fifo_wr_data;
  wire fifo_in_ready;
  wire [5:0] fifo_level;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_wr_valid <= 1'b0;
      fifo_wr_data <= 32'h00000000;
    end else begin
      fifo_wr_valid <= st_valid[decimation_active] && fifo_in_ready;
      fifo_wr_data <= st_data[decimation_active];
    end
  end

  // ==========================================================
  // Input back-pressure
  // The cascade cannot stall, so room is kept for every word that
  // may still be in flight when ready drops.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axis_tready <= 1'b0;
    end else begin
      s_axis_tready <= (fifo_level < `PTD_FILL_LIMIT);
    end
  end

  // ==========================================================
  // Output buffer
  ptd_fifo #(
    .WIDTH(`PTD_WORD_W),
    .DEPTH(`PTD_FIFO_DEPTH),
    .AW(`PTD_FIFO_AW)
  ) out_buffer (
    .clk(mclk),
    .rst_n(rst_n),
    .in_valid(fifo_wr_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_wr_data),
    .out_valid(m_axis_tvalid),
    .out_ready(m_axis_tready),
    .out_data(m_axis_tdata),
    .level(fifo_level)
  );

endmodule

/* testbench/ptd_dma_model.sv */
// Behavioural DMA read and write streamers.
// Assumes the bench fills txq and reads rxq.
`timescale 1ns/100ps
module ptd_dma_model (
  // Clock and stall control
  input wire clk,
  input wire slow,
  // Read stream into the decimator
  output logic src_valid,
  input wire src_ready,
  output logic [31:0] src_data,
  // Write stream from the decimator
  input wire snk_valid,
  output logic snk_ready,
  input wire [31:0] snk_data
);
  logic [31:0] txq[$];
  logic [31:0] rxq[$];
  integer seed = 23;
  logic tk;
  initial begin
    src_valid = 1'b0;
    src_data = 32'h0;
    snk_ready = 1'b0;
  end
  always @(posedge clk) begin
    tk = src_valid && src_ready;
    if (tk) void'(txq.pop_front());
    if (snk_valid && snk_ready) rxq.push_back(snk_data);
    #1;
    if (!src_valid || tk) begin
      src_valid = txq.size() != 0 && !(slow && $random(seed) % 2 != 0);
      src_data = src_valid ? txq[0] : ~src_data;
    end
    snk_ready = !(slow && $random(seed) % 2 != 0);
  end
endmodule

/* testbench/ptd_monitor.sv */
// Port checker for the decimator core.
// Assumes binding to ptd_pow2_decimator_core.
`timescale 1ns/100ps
module ptd_monitor (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Selection
  input wire [4:0] decimation_select,
  input wire decimation_select_wr,
  input wire [4:0] decimation_active,
  input wire select_rejected,
  // Streams
  input wire s_axis_tvalid,
  input wire s_axis_tready,
  input wire [31:0] s_axis_tdata,
  input wire m_axis_tvalid,
  input wire m_axis_tready,
  input wire [31:0] m_axis_tdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic seen;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) seen <= 1'b0;
    else if (s_axis_tvalid && s_axis_tready) seen <= 1'b1;
  end
  sequence bypass_beat;
    s_axis_tvalid && s_axis_tready && decimation_active == 5'h00 &&
      !m_axis_tvalid && !decimation_select_wr;
  endsequence
  sequence good_wr;
    decimation_select_wr && decimation_select <= 5'h10;
  endsequence
  a_out_hold: assert property (
    m_axis_tvalid && !m_axis_tready |=>
      m_axis_tvalid && $stable(m_axis_tdata)) else $error("out hold");
  a_sel_take: assert property (
    good_wr |=> decimation_active == $past(decimation_select))
    else $error("sel take");
  a_sel_refuse: assert property (
    decimation_select_wr && decimation_select > 5'h10 |=>
      select_rejected && $stable(decimation_active)) else $error("refuse");
  a_rej_cause: assert property (
    select_rejected |-> $past(decimation_select_wr) &&
      $past(decimation_select) > 5'h10) else $error("rej cause");
  a_sel_range: assert property (
    decimation_active <= 5'h10) else $error("sel range");
  a_sel_keep: assert property (
    !decimation_select_wr |=> $stable(decimation_active))
    else $error("sel keep");
  a_bypass_lat: assert property (
    bypass_beat |-> ##[1:4] m_axis_tvalid) else $error("bypass");
  a_no_early: assert property (
    m_axis_tvalid |-> seen) else $error("early beat");
endmodule

bind ptd_pow2_decimator_core ptd_monitor mon (.mclk, .reset_n,
  .decimation_select, .decimation_select_wr, .decimation_active,
  .select_rejected, .s_axis_tvalid, .s_axis_tready, .s_axis_tdata,
  .m_axis_tvalid, .m_axis_tready, .m_axis_tdata);

/* testbench/ptd_pow2_decimator_core_tb.sv */
// Self-checking bench for the decimator core.
// Assumes the checker and DMA model are compiled first.
`timescale 1ns/100ps
module ptd_pow2_decimator_core_tb;
  logic mclk, reset_n, wr, slow;
  logic [4:0] sel;
  logic [31:0] w;
  wire [4:0] act;
  wire rej, sv, sr, mv, mr;
  wire [31:0] sd, md;
  integer seed = 23, miscompares = 0, cmp_count = 0, i, n, m;
  logic [31:0] expq[$];
  logic [4:0] sel_model;
  int hl[17][11], hh[17][11], ph[17];
  logic [4:0] sels[5] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h08};
  ptd_pow2_decimator_core dut (.mclk(mclk), .reset_n(reset_n),
    .decimation_select(sel), .decimation_select_wr(wr),
    .decimation_active(act), .select_rejected(rej),
    .s_axis_tvalid(sv), .s_axis_tready(sr), .s_axis_tdata(sd),
    .m_axis_tvalid(mv), .m_axis_tready(mr), .m_axis_tdata(md));
  ptd_dma_model dma (.clk(mclk), .slow(slow), .src_valid(sv),
    .src_ready(sr), .src_data(sd), .snk_valid(mv), .snk_ready(mr),
    .snk_data(md));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task complete_run;
    $display("Compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic reset_dut;
    reset_n = 1'b0;
    wr = 1'b0;
    sel = 5'h00;
    sel_model = 5'h00;
    dma.txq.delete();
    repeat (8) @(posedge mclk);
    #1 check("reset idle", 32'h0, {30'h0, sr, mv});
    reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1 check("ready", 32'h1, {31'h0, sr});
    dma.rxq.delete();
  endtask
  task automatic write_sel(input logic [4:0] v);
    if (v <= 5'h10) sel_model = v;
    sel = v;
    wr = 1'b1;
    @(posedge mclk);
    #1 wr = 1'b0;
    check("active", {27'h0, sel_model}, {27'h0, act});
    check("rejected", {31'h0, v > 5'h10}, {31'h0, rej});
    @(posedge mclk);
    #1 check("rej drop", 32'h0, {31'h0, rej});
  endtask
  // Reference half-band: taps 3,0,-25,0,150,256 mirrored, over 512
  function automatic int hb(input int g, input bit up);
    int v[11];
    int acc;
    int k;
    for (k = 0; k < 11; k++) v[k] = up ? hh[g][k] : hl[g][k];
    acc = 3 * (v[0] + v[10]) - 25 * (v[2] + v[8]);
    acc = acc + 150 * (v[4] + v[6]) + 256 * v[5];
    acc = (acc + 256) >>> 9;
    if (acc > 32767) acc = 32767;
    if (acc < -32768) acc = -32768;
    return acc;
  endfunction
  // Push one input word through the reference cascade up to stage s
  task automatic model_word(input logic [31:0] d, input logic [4:0] s);
    int lo, hi, g, k;
    bit go;
    lo = $signed(d[15:0]);
    hi = $signed(d[31:16]);
    go = 1'b1;
    for (g = 1; g <= s && go; g++) begin
      for (k = 10; k > 0; k--) begin
        hl[g][k] = hl[g][k-1];
        hh[g][k] = hh[g][k-1];
      end
      hl[g][0] = lo;
      hh[g][0] = hi;
      ph[g] = 1 - ph[g];
      go = ph[g] == 0;
      if (go) begin
        lo = hb(g, 1'b0);
        hi = hb(g, 1'b1);
      end
    end
    if (go) expq.push_back({hi[15:0], lo[15:0]});
  endtask
  task automatic run_case(input logic [4:0] s, input integer cnt);
    int k;
    reset_dut();
    write_sel(s);
    expq.delete();
    for (i = 0; i < 17; i++) begin
      ph[i] = 0;
      for (k = 0; k < 11; k++) begin
        hl[i][k] = 0;
        hh[i][k] = 0;
      end
    end
    for (i = 0; i < cnt; i++) begin
      w = (s == 5'h00 || s > 5'h03) ? $random(seed) : 32'h8000_7fff;
      dma.txq.push_back(w);
      model_word(w, s);
    end
    n = 0;
    while (dma.rxq.size() < (cnt >> s) && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    repeat (40) @(posedge mclk);
    #1 check("count", cnt >> s, dma.rxq.size());
    for (i = 0; i < dma.rxq.size(); i++) begin
      w = dma.rxq[i];
      if (s == 5'h00) check("word", expq[i], w);
      else check("filtered", expq[i], w);
    end
    if (s != 5'h00 && s < 5'h04) check("dc", 32'h8000_7fff, w);
  endtask
  initial begin
    slow = 1'b0;
    reset_dut();
    write_sel(5'h10);
    write_sel(5'h11);
    write_sel(5'h1f);
    slow = 1'b1;
    run_case(5'h00, 200);
    slow = 1'b0;
    run_case(5'h00, 64);
    for (m = 0; m < 5; m++) begin
      slow = m[0];
      run_case(sels[m], 256);
    end
    complete_run();
  end
  initial begin
    #3_000_000;
    miscompares++;
    complete_run();
  end
endmodule
